// *** hdl/external_oscillator_control.sv ***
/*
  External oscillator control: the control register on AHB-Lite, mode
  decode for the drive circuit and pin claims, crystal valid flag and
  a small interrupt unit for valid changes.
  Assumes one AHB-Lite master, whole-word single transfers, and an
  amplitude detector pin from the analog oscillator.
*/
// Operation
// RQ1: valid flag bit 7 is read-only, meaningful only in crystal modes 11x.
// RQ2: valid flag reads 0 when crystal unused or unstable, 1 when stable.
// RQ3: mode code 100 runs the drive circuit as an RC oscillator.
// RQ4: three-bit frequency field in bits 2:0 selects one of eight drive bands.
// RQ5: crystal modes claim the input pin and the output pin.
// RQ6: capacitor, RC and CMOS modes claim only the output pin.
// RQ7: software makes the crossbar skip oscillator pins, sets their input mode.
// RQ8: before crystal mode, software drives both pins high then sets analog.
// RQ9: software waits at least 1 ms before checking the valid flag.
// RQ10: software polls valid, enables missing clock detector, then switches clock.
// RQ11: after a 32.768 kHz crystal settles, software may lower frequency to 000.
// RQ12: mode codes decode to off, CMOS, CMOS/2, capacitor, crystal, crystal/2.
// RQ13: bit 3 always reads 0 and ignores writes; other bits reset to 0.
`timescale 1ns/100ps
`include "ext_osc_defs.svh"

module external_oscillator_control
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // analog oscillator side
  input  wire logic              ampDetectPin,
  output ext_osc_pkg::osc_drive_s oscDrive,
  // interrupt
  output logic                   irq
);
  import ext_osc_pkg::*;

  // -----------------------------------------------------------------
  // registers and bus state
  // -----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic        wrPend;
  logic        rdPend;
  logic [9:0]  capIdx;
  logic        capOk;
  logic        validFlag;
  logic        validLast;

  // -----------------------------------------------------------------
  // address phase decode
  // -----------------------------------------------------------------
  wire         accept   = hsel && htrans[1] && hready;
  wire         addrOk   = (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'h0);
  wire  [7:0]  wdata8   = hwdata[7:0];
  wire         hitCtrl  = capOk && (capIdx == `EXT_OSC_CTRL_IDX);
  wire         hitStat  = capOk && (capIdx == `EXT_OSC_STAT_IDX);
  wire         hitMask  = capOk && (capIdx == `EXT_OSC_MASK_IDX);
  wire         wrCtrl   = wrPend && hitCtrl;
  wire         wrStat   = wrPend && hitStat;
  wire         wrMask   = wrPend && hitMask;

  // -----------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------
  wire  [2:0]  modeBits = ctrl[`EXT_OSC_MODE_HI:`EXT_OSC_MODE_LO];
  wire         xtalMode = (modeBits == MODE_XTAL) || (modeBits == MODE_XTAL_DIV2);
  wire         cmosMode = (modeBits == MODE_CMOS) || (modeBits == MODE_CMOS_DIV2);
  wire         rcMode   = (modeBits == MODE_RC);
  wire         capMode  = (modeBits == MODE_CAP);
  // code 001 is not a mode, so it leaves the circuit off
  wire         anyMode  = xtalMode || cmosMode || rcMode || capMode;

  // RQ12: mode codes to drive kind
  wire  osc_kind_e kind = xtalMode ? KIND_XTAL :
                          cmosMode ? KIND_CMOS :
                          // RQ3: code 100 runs RC
                          rcMode   ? KIND_RC   :
                          capMode  ? KIND_CAP  : KIND_OFF;

  // RQ5: crystal modes take both pins
  // RQ6: capacitor, RC and CMOS modes take only the output pin
  wire  osc_drive_s next_drive = '{
    driveOn:           anyMode,
    kind:              kind,
    divBy2:            (xtalMode || cmosMode) && modeBits[0],
    freqBand:          ctrl[`EXT_OSC_FREQ_HI:`EXT_OSC_FREQ_LO],
    oscInputPinClaim:  xtalMode,
    oscOutputPinClaim: anyMode
  };

  // RQ1: valid bit visible only in crystal modes
  // RQ13: bit 3 always reads zero
  wire  [7:0]  ctrlView = {xtalMode && validFlag, ctrl[6:4], 1'b0, ctrl[2:0]};
  wire  [7:0]  readVal  = hitCtrl ? ctrlView :
                          hitStat ? {6'h00, status} :
                          hitMask ? {6'h00, mask} : 8'h00;

  // events: valid went up or went down
  wire         evRise   = validFlag && !validLast;
  wire         evFall   = !validFlag && validLast;
  wire  [1:0]  evSet    = {evFall, evRise};
  wire  [1:0]  statClr  = wrStat ? wdata8[1:0] : 2'h0;
  // set wins over a same-cycle write-one-to-clear
  wire  [1:0]  next_status = (status & ~statClr) | evSet;

  // -----------------------------------------------------------------
  // crystal qualifier
  // -----------------------------------------------------------------
  // RQ2: qualifier runs only in crystal modes
  osc_valid_timer u_valid
  (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .enable       (xtalMode),
    .ampDetectPin (ampDetectPin),
    .validFlag    (validFlag)
  );

  // -----------------------------------------------------------------
  // bus phase tracking; reads insert one wait state so hrdata is a flop
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      capIdx <= 10'h000;
      capOk  <= 1'b0;
    end
    else if (hreadyout)
    begin
      wrPend <= accept && hwrite;
      rdPend <= accept && !hwrite;
      capIdx <= haddr[11:2];
      capOk  <= accept && addrOk;
    end
    else
    begin
      rdPend <= 1'b0;
    end
  end

  // read data captured during the wait state
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      hrdata <= 32'h00000000;
    else if (rdPend)
      hrdata <= {24'h000000, readVal};
  end

  assign hreadyout = !rdPend;
  assign hresp     = 1'b0;

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  // RQ13: masked write keeps bits 7 and 3 clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ctrl <= `EXT_OSC_CTRL_RESET;
    else if (wrCtrl)
      ctrl <= wdata8 & `EXT_OSC_CTRL_WMASK;
  end

  // -----------------------------------------------------------------
  // interrupt unit and drive outputs
  // -----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      status    <= `EXT_OSC_STAT_RESET;
      mask      <= `EXT_OSC_MASK_RESET;
      validLast <= 1'b0;
      irq       <= 1'b0;
      oscDrive  <= '0;
    end
    else
    begin
      status    <= next_status;
      validLast <= validFlag;
      irq       <= |(status & mask);  // one cycle behind status
      oscDrive  <= next_drive;
      if (wrMask)
        mask <= wdata8[1:0];
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_ctrl_write;
    wrCtrl;
  endsequence

  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  // read path: the flag reaches hrdata only in crystal modes
  a_valid_masked: assert property (rdPend && hitCtrl && !xtalMode // RQ1
                                   |=> !hrdata[7])
    else $error("valid bit visible outside crystal mode");
  a_valid_shows: assert property (rdPend && hitCtrl && xtalMode && validFlag // RQ2
                                  |=> hrdata[7])
    else $error("valid bit hidden while crystal stable");
  a_rc_drive: assert property (rcMode |=> oscDrive.kind == KIND_RC && oscDrive.driveOn) // RQ3
    else $error("code 100 did not select RC drive");
  a_freq_band: assert property (##1 oscDrive.freqBand == $past(ctrl[2:0])) // RQ4
    else $error("drive band does not follow frequency field");
  a_xtal_pins: assert property (xtalMode |=> oscDrive.oscInputPinClaim
                                && oscDrive.oscOutputPinClaim) // RQ5
    else $error("crystal mode did not claim both pins");
  a_single_pin: assert property ((cmosMode || rcMode || capMode) |=>
                                 !oscDrive.oscInputPinClaim
                                 && oscDrive.oscOutputPinClaim) // RQ6
    else $error("one-pin mode claimed wrong pins");
  a_off_decode: assert property (!anyMode |=> !oscDrive.driveOn
                                 && !oscDrive.oscOutputPinClaim) // RQ12
    else $error("off code left the drive running");
  a_div_decode: assert property ((modeBits == MODE_CMOS_DIV2 || modeBits == MODE_XTAL_DIV2)
                                 |=> oscDrive.divBy2) // RQ12
    else $error("divide by two not selected");
  a_ctrl_write: assert property (s_ctrl_write |=>
                                 ctrl == ($past(wdata8) & `EXT_OSC_CTRL_WMASK)
                                 && !ctrlView[3]) // RQ13
    else $error("control write stored wrong bits");
  a_read_timing: assert property (accept && !hwrite && hreadyout |=> s_read_wait)
    else $error("read wait state wrong");

endmodule : external_oscillator_control

// *** hdl/ext_osc_defs.svh ***
/*
  Offsets, field positions, reset values and timing counts for the
  external oscillator control block.
  Assumes a 100 MHz mclk and word-indexed registers on an AHB-Lite bus.
*/
`ifndef EXT_OSC_DEFS_SVH
`define EXT_OSC_DEFS_SVH

// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define EXT_OSC_CTRL_IDX     10'h09F
`define EXT_OSC_STAT_IDX     10'h0A0
`define EXT_OSC_MASK_IDX     10'h0A1

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define EXT_OSC_VALID_BIT    7
`define EXT_OSC_MODE_HI      6
`define EXT_OSC_MODE_LO      4
`define EXT_OSC_UNUSED_BIT   3
`define EXT_OSC_FREQ_HI      2
`define EXT_OSC_FREQ_LO      0
`define EXT_OSC_CTRL_RESET   8'h00
`define EXT_OSC_CTRL_WMASK   8'h77

// -----------------------------------------------------------------
// interrupt status and mask fields
// -----------------------------------------------------------------
`define EXT_OSC_STAT_RISE    0
`define EXT_OSC_STAT_FALL    1
`define EXT_OSC_STAT_RESET   2'h0
`define EXT_OSC_MASK_RESET   2'h0

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define EXT_OSC_MCLK_NS      10
`define EXT_OSC_SETTLE_NS    10000
`define EXT_OSC_SETTLE_CYC   ((`EXT_OSC_SETTLE_NS + `EXT_OSC_MCLK_NS - 1) / `EXT_OSC_MCLK_NS)

`endif

// *** hdl/ext_osc_pkg.sv ***
/*
  Types shared by the external oscillator control block.
  Assumes ext_osc_defs.svh supplies all numeric constants other than the enum codes below.
*/
package ext_osc_pkg;

  // -----------------------------------------------------------------
  // mode select codes as stored in the control register
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF       = 3'h0,
    MODE_CMOS      = 3'h2,
    MODE_CMOS_DIV2 = 3'h3,
    MODE_RC        = 3'h4,
    MODE_CAP       = 3'h5,
    MODE_XTAL      = 3'h6,
    MODE_XTAL_DIV2 = 3'h7
  } osc_mode_e;

  // kind of drive circuit actually running
  typedef enum logic [2:0] {
    KIND_OFF  = 3'h0,
    KIND_CMOS = 3'h1,
    KIND_RC   = 3'h2,
    KIND_CAP  = 3'h3,
    KIND_XTAL = 3'h4
  } osc_kind_e;

  // crystal stability qualifier, Gray along idle-settle-valid
  typedef enum logic [1:0] {
    QUAL_IDLE   = 2'h0,
    QUAL_SETTLE = 2'h1,
    QUAL_VALID  = 2'h3
  } qual_state_e;

  // controls handed to the analog drive circuit and pin mux
  typedef struct packed {
    logic      driveOn;
    osc_kind_e kind;
    logic      divBy2;
    logic [2:0] freqBand;
    logic      oscInputPinClaim;
    logic      oscOutputPinClaim;
  } osc_drive_s;

endpackage : ext_osc_pkg

// *** hdl/osc_valid_timer.sv ***
/*
  Crystal valid qualifier: synchronises the amplitude detector pin and
  only reports valid after it has stayed good for the settle time.
  Assumes enable is a same-clock level that is high only in crystal mode.
*/
`timescale 1ns/100ps
`include "ext_osc_defs.svh"

module osc_valid_timer
(
  // clock and reset
  input  wire logic mclk,
  input  wire logic sys_rst,
  // control and pin
  input  wire logic enable,
  input  wire logic ampDetectPin,
  // result
  output logic      validFlag
);
  import ext_osc_pkg::*;

  localparam logic [10:0] SETTLE = 11'(`EXT_OSC_SETTLE_CYC);

  logic        syncA;
  logic        syncB;
  logic        syncC;
  logic        ampGood;
  logic [10:0] count;
  qual_state_e state;
  qual_state_e next_state;

  // three-stage synchroniser, level accepted once the last two agree
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      syncA   <= 1'b0;
      syncB   <= 1'b0;
      syncC   <= 1'b0;
      ampGood <= 1'b0;
    end
    else
    begin
      syncA <= ampDetectPin;
      syncB <= syncA;
      syncC <= syncB;
      if (syncB == syncC)
        ampGood <= syncC;
    end
  end

  // settle state machine; a dropout restarts the wait
  always_comb
  begin
    next_state = state;
    case (state)
      QUAL_IDLE:   if (enable && ampGood) next_state = QUAL_SETTLE;
      QUAL_SETTLE: if (!enable || !ampGood) next_state = QUAL_IDLE;
                   else if (count == SETTLE) next_state = QUAL_VALID;
      QUAL_VALID:  if (!enable || !ampGood) next_state = QUAL_IDLE;
      default:     next_state = QUAL_IDLE;
    endcase
  end

  // RQ2: flag stays low until stable
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state     <= QUAL_IDLE;
      count     <= 11'h000;
      validFlag <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      count     <= (next_state == QUAL_SETTLE) ? count + 11'h001 : 11'h000;
      validFlag <= (next_state == QUAL_VALID);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_valid_needs_enable: assert property (validFlag |-> $past(enable)) // RQ2
    else $error("valid flag set outside crystal mode");

endmodule : osc_valid_timer

// *** verification/osc_partner.sv ***
/*
  Far-side crystal model: the amplitude-good pin rises a while after
  crystal drive starts and drops on a commanded dropout.
  Assumes the drive struct from the control block, same clock.
*/
`timescale 1ns/100ps

module osc_partner
#(
  parameter int START_CYC = 200
)
(
  // clock
  input  wire logic                     mclk,
  // drive and fault command
  input  wire ext_osc_pkg::osc_drive_s  oscDrive,
  input  wire logic                     dropout,
  // amplitude result
  output logic                          ampDetectPin
);
  import ext_osc_pkg::*;

  int age;

  // bias only builds while a crystal is driven; dropout mimics a stalled crystal
  always_ff @(posedge mclk)
  begin
    // crystal sees only pins left to the oscillator
    if (oscDrive.driveOn && oscDrive.kind == KIND_XTAL && oscDrive.oscInputPinClaim
        && oscDrive.oscOutputPinClaim && !dropout)
      age <= (age < START_CYC) ? age + 1 : age;
    else
      age <= 0;
  end

  assign ampDetectPin = (age >= START_CYC);
endmodule : osc_partner

// *** verification/external_oscillator_control_tb_top.sv ***
/*
  Self-checking bench: AHB-Lite master tasks, register model, crystal
  start-up, valid interrupt and pin claims of every mode.
  Assumes one slave whose hreadyout is the bus hready.
*/
`timescale 1ns/100ps
`include "ext_osc_defs.svh"

module external_oscillator_control_tb_top;
  import ext_osc_pkg::*;

  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  localparam logic [31:0] ACTRL = 32'(`EXT_OSC_CTRL_IDX) << 2;
  localparam logic [31:0] ASTAT = 32'(`EXT_OSC_STAT_IDX) << 2;
  localparam logic [31:0] AMASK = 32'(`EXT_OSC_MASK_IDX) << 2;
  logic        mclk = 0, sysRst = 1, hsel = 0, hwrite = 0, dropout = 0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = '0, hwdata = '0, rd, seed = 32'hA999;
  logic        hreadyout, hresp, irq, ampDetectPin;
  logic [31:0] hrdata;
  osc_drive_s  oscDrive;
  int          errors = 0, checked = 0, ctrlM, n;
  time         t0;

  external_oscillator_control external_oscillator_control_inst
  (.mclk(mclk), .sys_rst(sysRst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .ampDetectPin(ampDetectPin), .oscDrive(oscDrive), .irq(irq));

  osc_partner #(.START_CYC(200)) osc_partner_inst
  (.mclk(mclk), .oscDrive(oscDrive), .dropout(dropout), .ampDetectPin(ampDetectPin));

  initial
  begin
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // expected drive controls for a mode code and band
  function automatic osc_drive_s expDrive(int m, int f);
    osc_drive_s d;
    d = '0;
    d.driveOn = (m >= 2);
    d.kind = (m >= 6) ? KIND_XTAL : (m == 5) ? KIND_CAP : (m == 4) ? KIND_RC :
             (m >= 2) ? KIND_CMOS : KIND_OFF;
    d.divBy2 = (m == 3 || m == 7);
    d.freqBand = 3'(f);
    d.oscInputPinClaim = (m >= 6);
    d.oscOutputPinClaim = (m >= 2);
    return d;
  endfunction : expDrive

  task automatic summarize();
    if (errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // wait for hready at the falling edge so the rising-edge sample is settled
  task automatic waitReady();
    int k;
    k = 0;
    do
    begin
      @(negedge mclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      errors++;
      summarize();
    end
  endtask : waitReady

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    waitReady();
    @(posedge mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    waitReady();
    @(posedge mclk);
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask : bus

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge mclk);
    sysRst <= 1'b0;
    @(posedge mclk);
    bus(0, ACTRL, 0);
    chk("ctrl reset", rd, 32'h0);
    bus(0, ASTAT, 0);
    chk("stat reset", rd, 32'h0);
    chk("drive reset", 32'(oscDrive), 32'h0);
    // every mode code with a random band and junk in bits 7 and 3
    for (int m = 0; m < 8; m++)
    begin
      ctrlM = (m << 4) | int'(xs() & 32'h7);
      bus(1, ACTRL, (xs() & 32'hFFFFFF88) | 32'(ctrlM));
      bus(0, ACTRL, 0);
      chk("ctrl rw", rd, 32'(ctrlM));
      chk("drive", 32'(oscDrive), 32'(expDrive(m, ctrlM & 7)));
    end
    // unmapped place: write lost, read zero
    bus(1, 32'h300, xs());
    bus(0, 32'h300, 0);
    chk("unmapped", rd, 32'h0);
    bus(1, ACTRL, 32'h0);
    bus(1, AMASK, 32'h3);
    // pins parked before crystal enable: drive is off at this point
    chk("pins free", 32'(oscDrive), 32'(expDrive(0, 0)));
    bus(1, ACTRL, 32'h67);
    t0 = $time;
    bus(0, ACTRL, 0);
    chk("valid early", rd, 32'h67);
    // poll the valid flag before any clock switch
    n = 0;
    do
    begin
      bus(0, ACTRL, 0);
      n++;
    end while (rd[7] !== 1'b1 && n < 600);
    if (rd[7] !== 1'b1)
    begin
      errors++;
      summarize();
    end
    chk("valid late", rd, 32'hE7);
    // crystal start in the partner plus the qualifier's settle time
    chk("settle", 32'(($time - t0) >= (200 + `EXT_OSC_SETTLE_CYC) * `EXT_OSC_MCLK_NS),
        32'h1);
    bus(0, ASTAT, 0);
    chk("rise stat", rd, 32'h1);
    chk("irq rise", 32'(irq), 32'h1);
    // lowering the band keeps the crystal valid
    bus(1, ACTRL, 32'h60);
    bus(0, ACTRL, 0);
    chk("low band", rd, 32'hE0);
    bus(1, ASTAT, 32'h1);
    bus(0, ASTAT, 0);
    chk("w1c", rd, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    // dropout clears valid and raises the fall event
    dropout <= 1'b1;
    n = 0;
    do
    begin
      bus(0, ASTAT, 0);
      n++;
    end while (rd[1] !== 1'b1 && n < 50);
    if (rd[1] !== 1'b1)
    begin
      errors++;
      summarize();
    end
    bus(0, ACTRL, 0);
    chk("valid drop", rd, 32'h60);
    chk("irq fall", 32'(irq), 32'h1);
    bus(1, AMASK, 32'h0);
    bus(0, ASTAT, 0);
    chk("masked stat", rd, 32'h2);
    chk("irq masked", 32'(irq), 32'h0);
    dropout <= 1'b0;
    summarize();
  end
endmodule : external_oscillator_control_tb_top
